// ===== inc/srg_pkg.sv
// Package for the suspend/resume command gate of a serial flash.
// Holds opcodes, operation kinds, timing counts and the status carrier.
package srg_pkg;

    localparam logic [7:0] OPC_SUSPEND = 8'hB0;
    localparam logic [7:0] OPC_RESUME = 8'hD0;
    localparam logic [7:0] OPC_PROT_PREFIX = 8'h3D;

    localparam int CLK_PERIOD_NS = 10;
    localparam int RESUME_LATENCY_NS = 20000;
    localparam int RESUME_LATENCY_CYC =
        (RESUME_LATENCY_NS / CLK_PERIOD_NS < 1) ? 1 : RESUME_LATENCY_NS / CLK_PERIOD_NS;
    localparam int RES_CNT_W = 12;
    localparam logic [RES_CNT_W-1:0] RES_CNT_LOAD = RES_CNT_W'(RESUME_LATENCY_CYC);

    localparam int SYNC_W = 4;
    // Idle pin levels: chip select and reset pin high, serial clock and data low.
    localparam logic [SYNC_W-1:0] SYNC_RST_VAL = 4'h9;

    typedef enum logic [1:0]
    {
        SRG_OP_NONE = 2'b00,
        SRG_OP_PROG1 = 2'b01,
        SRG_OP_PROG2 = 2'b10,
        SRG_OP_ERASE = 2'b11
    } srg_op_t;

    typedef enum logic [1:0]
    {
        SRG_ST_IDLE = 2'b00,
        SRG_ST_RUN = 2'b01,
        SRG_ST_RESTART = 2'b10
    } srg_state_t;

    typedef struct packed {
        logic erase_suspend_flag;
        logic prog_suspend_buf2_flag;
        logic prog_suspend_buf1_flag;
        logic busy;
    } srg_status_t;

endpackage

// ===== core/srg_sync.sv
// Three-stage synchroniser for pins from outside the clock domain.
// A pin's new level is taken once the second and third stages agree.
`timescale 1ns/1ps
module srg_sync
(
    input wire logic clk_i, // System clock.
    input wire logic srst_i, // Synchronous reset, active high.
    input wire logic [srg_pkg::SYNC_W-1:0] pin_i, // Raw pin levels.
    output logic [srg_pkg::SYNC_W-1:0] val_o // Filtered levels.
);
    logic [srg_pkg::SYNC_W-1:0] s1_r;
    logic [srg_pkg::SYNC_W-1:0] s2_r;
    logic [srg_pkg::SYNC_W-1:0] s3_r;

    genvar g;
    generate
        for (g = 0; g < srg_pkg::SYNC_W; g++)
        begin : g_bit
            always_ff @(posedge clk_i)
            begin
                if (srst_i)
                begin
                    s1_r[g] <= srg_pkg::SYNC_RST_VAL[g];
                    s2_r[g] <= srg_pkg::SYNC_RST_VAL[g];
                    s3_r[g] <= srg_pkg::SYNC_RST_VAL[g];
                    val_o[g] <= srg_pkg::SYNC_RST_VAL[g];
                end
                else
                begin
                    s1_r[g] <= pin_i[g];
                    s2_r[g] <= s1_r[g];
                    s3_r[g] <= s2_r[g];
                    if (s2_r[g] == s3_r[g])
                    begin
                        val_o[g] <= s3_r[g];
                    end
                end
            end
        end
    endgenerate
endmodule // srg_sync

// ===== core/srg_gate.sv
// Suspend/resume command gate of a serial flash: decodes the opcode of each frame,
// decides acceptance while program or erase is suspended, and runs suspend/resume.
// Assumes the array engine reports operation start and completion on the system clock.
//
// Behaviour
// - While suspended, protection, lockdown, freeze and security program commands are refused.
// - While suspended, reads of protection, lockdown, security, config, status and ID pass.
// - A page-to-buffer transfer is refused only if that buffer's program is suspended.
// - A page-to-buffer compare is refused only if that buffer's program is suspended.
// - While suspended, entering either power-down mode or leaving deep power-down is refused.
// - Hardware pin reset and the software reset command are accepted during suspension.
// - Resume is opcode D0h alone and bytes after the opcode are ignored.
// - Resume starts at chip select deassertion and completes within the resume latency.
// - Resume clears the applicable buffer-1, buffer-2 or erase suspend flag to 0.
// - After resume the busy flag shows busy while the resumed operation runs.
// - With erase and program both suspended, one resume restarts only the program.
// - A suspend received while a resume is still restarting is ignored.
// - Suspend is opcode B0h, acts at deassertion and sets the relevant suspend flag to 1.
// - A combined suspension shows the erase flag and one program flag both set.
`timescale 1ns/1ps
module srg_gate
#(
    parameter logic [7:0] OPC_XFER_BUF1 = 8'h01, // Page to buffer 1 transfer.
    parameter logic [7:0] OPC_XFER_BUF2 = 8'h02, // Page to buffer 2 transfer.
    parameter logic [7:0] OPC_CMP_BUF1 = 8'h03, // Page to buffer 1 compare.
    parameter logic [7:0] OPC_CMP_BUF2 = 8'h04, // Page to buffer 2 compare.
    parameter logic [7:0] OPC_DEEP_PD = 8'h05, // Enter deep power-down.
    parameter logic [7:0] OPC_DEEP_PD_EXIT = 8'h06, // Resume from deep power-down.
    parameter logic [7:0] OPC_ULTRA_PD = 8'h07, // Enter ultra-deep power-down.
    parameter logic [7:0] OPC_FREEZE = 8'h08, // Freeze lockdown state.
    parameter logic [7:0] OPC_SEC_PROG = 8'h09, // Program security area.
    parameter logic [7:0] OPC_SW_RESET = 8'h0A // Software reset first byte.
)
(
    input wire logic clk_i, // System clock, 100 MHz.
    input wire logic srst_i, // Synchronous reset, active high.
    input wire logic cs_n_i, // Chip select pin, active low.
    input wire logic sck_i, // Serial clock pin.
    input wire logic si_i, // Serial data input pin.
    input wire logic reset_n_i, // Hardware reset pin, active low.
    input wire logic op_start_i, // Array engine starts an operation.
    input wire srg_pkg::srg_op_t op_kind_i, // Kind of the operation being started.
    input wire logic op_done_i, // Running operation has completed.
    output logic op_suspend_o, // Pulse: pause the running operation.
    output logic op_resume_o, // Pulse: restart the paused operation.
    output srg_pkg::srg_op_t op_resume_kind_o, // Kind restarted by op_resume_o.
    output logic op_abort_o, // Reset aborts all suspended work: pulse for software reset, held while reset pin is low.
    output logic frame_allow_o, // Current frame's opcode may proceed.
    output logic frame_refuse_o, // Current frame's opcode is refused.
    output logic cmd_exec_o, // Pulse at deassertion: accepted command ends.
    output logic [7:0] cmd_opcode_o, // Opcode of the current or last frame.
    output srg_pkg::srg_status_t status_o // Suspend flags and busy.
);
    logic [srg_pkg::SYNC_W-1:0] pins_s;
    logic cs_n_q;
    logic sck_q;
    logic rst_pin_q;
    logic cs_n_d_r;
    logic sck_d_r;
    logic [7:0] shift_r;
    logic [3:0] bit_cnt_r;
    logic op_valid_r;
    logic any_susp;
    logic allow_nxt;
    logic frame_end;
    logic sck_rise;
    logic sw_reset;
    logic do_reset;
    logic do_suspend;
    logic do_resume;
    logic es_r;
    logic ps1_r;
    logic ps2_r;
    srg_pkg::srg_state_t state_r;
    srg_pkg::srg_op_t run_kind_r;
    logic [srg_pkg::RES_CNT_W-1:0] res_cnt_r;

    srg_sync u_sync
    (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .pin_i({reset_n_i, si_i, sck_i, cs_n_i}),
        .val_o(pins_s)
    );

    assign cs_n_q = pins_s[0];
    assign sck_q = pins_s[1];
    assign rst_pin_q = ~pins_s[3];
    assign sck_rise = sck_q & ~sck_d_r & ~cs_n_q;
    assign frame_end = cs_n_q & ~cs_n_d_r;
    assign any_susp = es_r | ps1_r | ps2_r;

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            cs_n_d_r <= 1'b1;
            sck_d_r <= 1'b0;
        end
        else
        begin
            cs_n_d_r <= cs_n_q;
            sck_d_r <= sck_q;
        end
    end

    // Only the first byte is kept; later bytes are ignored.
    always_ff @(posedge clk_i)
    begin
        if (srst_i || cs_n_q)
        begin
            bit_cnt_r <= 4'h0;
            op_valid_r <= 1'b0;
            if (srst_i)
            begin
                shift_r <= 8'h00;
            end
        end
        else if (sck_rise && !op_valid_r)
        begin
            shift_r <= {shift_r[6:0], pins_s[2]};
            bit_cnt_r <= bit_cnt_r + 4'h1;
            op_valid_r <= (bit_cnt_r == 4'h7);
        end
    end

    assign cmd_opcode_o = shift_r;

    always_comb
    begin
        allow_nxt = 1'b1;
        if (any_susp)
        begin
            if (shift_r == srg_pkg::OPC_PROT_PREFIX || shift_r == OPC_FREEZE
                || shift_r == OPC_SEC_PROG)
            begin
                allow_nxt = 1'b0;
            end
            if (shift_r == OPC_DEEP_PD || shift_r == OPC_DEEP_PD_EXIT
                || shift_r == OPC_ULTRA_PD)
            begin
                allow_nxt = 1'b0;
            end
            if ((shift_r == OPC_XFER_BUF1 && ps1_r) || (shift_r == OPC_XFER_BUF2 && ps2_r))
            begin
                allow_nxt = 1'b0;
            end
            if ((shift_r == OPC_CMP_BUF1 && ps1_r) || (shift_r == OPC_CMP_BUF2 && ps2_r))
            begin
                allow_nxt = 1'b0;
            end
        end
        if (shift_r == OPC_SW_RESET)
        begin
            allow_nxt = 1'b1;
        end
    end

    // The verdict follows the opcode register directly, so it is right from the first valid cycle.
    assign frame_allow_o = op_valid_r & allow_nxt;
    assign frame_refuse_o = op_valid_r & ~allow_nxt;

    assign cmd_exec_o = frame_end & op_valid_r & allow_nxt;
    assign do_resume = cmd_exec_o && shift_r == srg_pkg::OPC_RESUME;
    assign sw_reset = cmd_exec_o && shift_r == OPC_SW_RESET;
    assign do_reset = sw_reset | rst_pin_q;
    assign do_suspend = cmd_exec_o && shift_r == srg_pkg::OPC_SUSPEND
        && state_r == srg_pkg::SRG_ST_RUN;

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            state_r <= srg_pkg::SRG_ST_IDLE;
            run_kind_r <= srg_pkg::SRG_OP_NONE;
            res_cnt_r <= '0;
            es_r <= 1'b0;
            ps1_r <= 1'b0;
            ps2_r <= 1'b0;
            op_suspend_o <= 1'b0;
            op_resume_o <= 1'b0;
            op_resume_kind_o <= srg_pkg::SRG_OP_NONE;
            op_abort_o <= 1'b0;
        end
        else
        begin
            op_suspend_o <= 1'b0;
            op_resume_o <= 1'b0;
            op_abort_o <= 1'b0;
            if (do_reset)
            begin
                op_abort_o <= 1'b1;
                es_r <= 1'b0;
                ps1_r <= 1'b0;
                ps2_r <= 1'b0;
                state_r <= srg_pkg::SRG_ST_IDLE;
                run_kind_r <= srg_pkg::SRG_OP_NONE;
            end
            else
            begin
                case (state_r)
                    srg_pkg::SRG_ST_IDLE:
                    begin
                        if (op_start_i && op_kind_i != srg_pkg::SRG_OP_NONE)
                        begin
                            state_r <= srg_pkg::SRG_ST_RUN;
                            run_kind_r <= op_kind_i;
                        end
                        else if (do_resume && any_susp)
                        begin
                            state_r <= srg_pkg::SRG_ST_RESTART;
                            res_cnt_r <= srg_pkg::RES_CNT_LOAD;
                            op_resume_o <= 1'b1;
                            if (ps1_r)
                            begin
                                ps1_r <= 1'b0;
                                run_kind_r <= srg_pkg::SRG_OP_PROG1;
                                op_resume_kind_o <= srg_pkg::SRG_OP_PROG1;
                            end
                            else if (ps2_r)
                            begin
                                ps2_r <= 1'b0;
                                run_kind_r <= srg_pkg::SRG_OP_PROG2;
                                op_resume_kind_o <= srg_pkg::SRG_OP_PROG2;
                            end
                            else
                            begin
                                es_r <= 1'b0;
                                run_kind_r <= srg_pkg::SRG_OP_ERASE;
                                op_resume_kind_o <= srg_pkg::SRG_OP_ERASE;
                            end
                        end
                    end
                    srg_pkg::SRG_ST_RESTART:
                    begin
                        res_cnt_r <= res_cnt_r - 1'b1;
                        if (op_done_i)
                        begin
                            state_r <= srg_pkg::SRG_ST_IDLE;
                            run_kind_r <= srg_pkg::SRG_OP_NONE;
                        end
                        else if (res_cnt_r <= 1)
                        begin
                            state_r <= srg_pkg::SRG_ST_RUN;
                        end
                    end
                    srg_pkg::SRG_ST_RUN:
                    begin
                        if (op_done_i)
                        begin
                            state_r <= srg_pkg::SRG_ST_IDLE;
                            run_kind_r <= srg_pkg::SRG_OP_NONE;
                        end
                        // erase flag may stay set alongside
                        else if (do_suspend)
                        begin
                            op_suspend_o <= 1'b1;
                            state_r <= srg_pkg::SRG_ST_IDLE;
                            run_kind_r <= srg_pkg::SRG_OP_NONE;
                            case (run_kind_r)
                                srg_pkg::SRG_OP_PROG1: ps1_r <= 1'b1;
                                srg_pkg::SRG_OP_PROG2: ps2_r <= 1'b1;
                                srg_pkg::SRG_OP_ERASE: es_r <= 1'b1;
                                default: es_r <= es_r;
                            endcase
                        end
                    end
                    default:
                    begin
                        state_r <= srg_pkg::SRG_ST_IDLE;
                    end
                endcase
            end
        end
    end

    assign status_o.busy = (state_r != srg_pkg::SRG_ST_IDLE);
    assign status_o.erase_suspend_flag = es_r;
    assign status_o.prog_suspend_buf2_flag = ps2_r;
    assign status_o.prog_suspend_buf1_flag = ps1_r;
endmodule // srg_gate

// ===== tb/srg_gate_sva.sv
// Checker for the suspend/resume gate, attached by bind.
// Sees only the gate's ports; one clock with a synchronous reset.
`timescale 1ns/1ps
module srg_gate_sva
(
    input wire logic clk_i, // System clock.
    input wire logic srst_i, // Synchronous reset.
    input wire logic reset_n_i, // Reset pin, active low.
    input wire logic op_suspend_o, // Suspend pulse.
    input wire logic op_resume_o, // Resume pulse.
    input wire srg_pkg::srg_op_t op_resume_kind_o, // Resumed kind.
    input wire logic op_abort_o, // Abort pulse; held while reset pin is low.
    input wire logic frame_refuse_o, // Frame refused.
    input wire logic cmd_exec_o, // Command executes.
    input wire logic [7:0] cmd_opcode_o, // Frame opcode.
    input wire srg_pkg::srg_status_t status_o // Flags and busy.
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    logic [3:0] prev_r;
    logic [11:0] hold_r;
    // Keeps the last status and a window that ends before the restart does.
    always_ff @(posedge clk_i)
    begin
        prev_r <= status_o;
        if (srst_i)
            hold_r <= 12'h000;
        else if (op_resume_o)
            hold_r <= srg_pkg::RES_CNT_LOAD - 12'h00A;
        else if (!status_o.busy)
            hold_r <= 12'h000;
        else if (hold_r != 12'h000)
            hold_r <= hold_r - 12'h001;
    end
    a_resume_busy: assert property (op_resume_o |-> status_o.busy)
        else $error("resume without busy");
    a_resume_clear: assert property (op_resume_o |-> prev_r[op_resume_kind_o]
        && !status_o[op_resume_kind_o]) else $error("resume flag not cleared");
    a_resume_cause: assert property (op_resume_o |-> $past(cmd_exec_o)
        && $past(cmd_opcode_o) == srg_pkg::OPC_RESUME) else $error("resume without frame");
    a_prog_first: assert property (op_resume_o && prev_r[2:1] != 2'h0 |->
        op_resume_kind_o != srg_pkg::SRG_OP_ERASE && status_o[3] == prev_r[3])
        else $error("erase resumed before program");
    a_suspend_flag: assert property (op_suspend_o |-> status_o[3:1] != 3'h0
        && !status_o.busy) else $error("suspend left no flag");
    a_restart_deaf: assert property (hold_r != 12'h000 |-> !op_suspend_o)
        else $error("suspend taken during restart");
    a_refuse_quiet: assert property (frame_refuse_o |-> !cmd_exec_o ##1
        !op_resume_o && !op_suspend_o) else $error("refused frame acted");
    a_pin_abort: assert property (!reset_n_i [*7] |-> op_abort_o
        && status_o == 4'h0) else $error("reset pin did not abort");
    c_combined: cover property (op_resume_o && status_o.erase_suspend_flag);
    c_refuse: cover property (frame_refuse_o);
    c_abort: cover property (op_abort_o);
endmodule // srg_gate_sva

// ===== tb/srg_host_model.sv
// Host side of the serial command link: chip select, serial clock, data.
// Runs on the system clock; the serial clock averages a 125 ns period in frames.
`timescale 1ns/1ps
module srg_host_model
(
    input wire logic clk_i, // System clock.
    output logic cs_n_o, // Chip select, active low.
    output logic sck_o, // Serial clock, still outside frames.
    output logic si_o // Serial data, MSB first.
);
    initial
    begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic put_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            si_o <= b[i];
            w(6);
            sck_o <= 1'b1;
            w(6 + (i % 2));
            sck_o <= 1'b0;
        end
    endtask
    task automatic frame(input logic [7:0] opc, input logic [7:0] tail, input bit ext);
        w(1);
        cs_n_o <= 1'b0;
        w(6);
        put_byte(opc);
        if (ext)
            put_byte(tail);
        w(6);
        cs_n_o <= 1'b1;
        si_o <= ~si_o;
        w(12);
    endtask
endmodule // srg_host_model

// ===== tb/tb_srg_gate.sv
// Self-checking bench of the suspend/resume gate.
// The host model drives the link; the bench plays the array engine.
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin \
        n_checks++; \
        if ((g) !== (e)) \
        begin \
            bad_count++; \
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
        end \
    end
module tb_srg_gate;
    localparam logic [7:0] XB1 = 8'h53, XB2 = 8'h55, CB1 = 8'h60, CB2 = 8'h61;
    localparam logic [7:0] DPD = 8'hB9, DPX = 8'hAB, UPD = 8'h79, FRZ = 8'h34;
    localparam logic [7:0] SEC = 8'h9B, SWR = 8'hF0;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic reset_n_i = 1'b1;
    logic op_start_i = 1'b0;
    logic op_done_i = 1'b0;
    srg_pkg::srg_op_t op_kind_i = srg_pkg::SRG_OP_NONE;
    srg_pkg::srg_op_t op_resume_kind_o;
    srg_pkg::srg_status_t status_o;
    logic cs_n_i, sck_i, si_i, op_suspend_o, op_resume_o, op_abort_o;
    logic frame_allow_o, frame_refuse_o, cmd_exec_o, saw_ref, saw_all;
    logic [7:0] cmd_opcode_o;
    logic [7:0] bad_t [6] = '{8'h3D, FRZ, SEC, DPD, DPX, UPD};
    logic [7:0] ok_t [4] = '{8'hD7, 8'h9F, 8'h77, 8'h35};
    int bad_count = 0;
    int n_checks = 0;
    int n_exec = 0;
    int n_susp = 0;
    int n_abort = 0;
    srg_pkg::srg_op_t rk = srg_pkg::SRG_OP_NONE;
    srg_host_model u_srg_host_model (.clk_i(clk_i), .cs_n_o(cs_n_i), .sck_o(sck_i),
        .si_o(si_i));
    srg_gate #(.OPC_XFER_BUF1(XB1), .OPC_XFER_BUF2(XB2), .OPC_CMP_BUF1(CB1),
        .OPC_CMP_BUF2(CB2), .OPC_DEEP_PD(DPD), .OPC_DEEP_PD_EXIT(DPX), .OPC_ULTRA_PD(UPD),
        .OPC_FREEZE(FRZ), .OPC_SEC_PROG(SEC), .OPC_SW_RESET(SWR)) u_srg_gate (
        .clk_i(clk_i), .srst_i(srst_i), .cs_n_i(cs_n_i), .sck_i(sck_i), .si_i(si_i),
        .reset_n_i(reset_n_i), .op_start_i(op_start_i), .op_kind_i(op_kind_i),
        .op_done_i(op_done_i), .op_suspend_o(op_suspend_o), .op_resume_o(op_resume_o),
        .op_resume_kind_o(op_resume_kind_o), .op_abort_o(op_abort_o),
        .frame_allow_o(frame_allow_o), .frame_refuse_o(frame_refuse_o),
        .cmd_exec_o(cmd_exec_o), .cmd_opcode_o(cmd_opcode_o), .status_o(status_o));
    initial
    begin
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        if (!cs_n_i)
        begin
            saw_ref = saw_ref | frame_refuse_o;
            saw_all = saw_all | frame_allow_o;
        end
        if (cmd_exec_o === 1'b1)
            n_exec++;
        if (op_suspend_o === 1'b1)
            n_susp++;
        if (op_abort_o === 1'b1)
            n_abort++;
        if (op_resume_o === 1'b1)
            rk = op_resume_kind_o;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic st(input logic [3:0] e);
        `CHK("status", e, status_o)
    endtask
    task automatic frm(input logic [7:0] opc);
        u_srg_host_model.frame(opc, 8'h00, 1'b0);
    endtask
    task automatic cmd(input logic [7:0] opc, input logic er);
        @(negedge clk_i);
        saw_ref = 1'b0;
        saw_all = 1'b0;
        n_exec = 0;
        frm(opc);
        `CHK("refuse", er, saw_ref)
        `CHK("allow", ~er, saw_all)
        `CHK("exec", ~er, n_exec == 1)
        `CHK("opcode", opc, cmd_opcode_o)
    endtask
    task automatic start(input srg_pkg::srg_op_t k);
        op_kind_i <= k;
        op_start_i <= 1'b1;
        w(1);
        op_start_i <= 1'b0;
        w(2);
    endtask
    task automatic done();
        w(srg_pkg::RESUME_LATENCY_CYC);
        op_done_i <= 1'b1;
        w(1);
        op_done_i <= 1'b0;
        w(2);
    endtask
    initial
    begin
        repeat (100000) @(posedge clk_i);
        bad_count++;
        close_out();
    end
    initial
    begin
        w(16);
        srst_i <= 1'b0;
        w(8);
        st(4'h0);
        start(srg_pkg::SRG_OP_PROG1);
        st(4'h1);
        u_srg_host_model.frame(srg_pkg::OPC_SUSPEND, srg_pkg::OPC_RESUME, 1'b1);
        st(4'h2);
        foreach (bad_t[i]) cmd(bad_t[i], 1'b1);
        cmd(XB1, 1'b1);
        cmd(CB1, 1'b1);
        cmd(XB2, 1'b0);
        cmd(CB2, 1'b0);
        foreach (ok_t[i]) cmd(ok_t[i], 1'b0);
        st(4'h2);
        frm(srg_pkg::OPC_RESUME);
        st(4'h1);
        `CHK("kind", srg_pkg::SRG_OP_PROG1, rk)
        frm(srg_pkg::OPC_SUSPEND);
        st(4'h1);
        `CHK("suspends", 1, n_susp)
        done();
        st(4'h0);
        $display("test single_suspend done");
        start(srg_pkg::SRG_OP_ERASE);
        frm(srg_pkg::OPC_SUSPEND);
        st(4'h8);
        cmd(CB2, 1'b0);
        start(srg_pkg::SRG_OP_PROG2);
        frm(srg_pkg::OPC_SUSPEND);
        st(4'hC);
        cmd(XB1, 1'b0);
        cmd(XB2, 1'b1);
        cmd(CB2, 1'b1);
        cmd(CB1, 1'b0);
        frm(srg_pkg::OPC_RESUME);
        st(4'h9);
        `CHK("kind", srg_pkg::SRG_OP_PROG2, rk)
        done();
        st(4'h8);
        frm(srg_pkg::OPC_RESUME);
        st(4'h1);
        `CHK("kind", srg_pkg::SRG_OP_ERASE, rk)
        w(srg_pkg::RESUME_LATENCY_CYC);
        frm(srg_pkg::OPC_SUSPEND);
        st(4'h8);
        frm(srg_pkg::OPC_RESUME);
        st(4'h1);
        done();
        st(4'h0);
        $display("test combined_suspend done");
        start(srg_pkg::SRG_OP_PROG1);
        frm(srg_pkg::OPC_SUSPEND);
        cmd(SWR, 1'b0);
        `CHK("abort", 1, n_abort)
        st(4'h0);
        start(srg_pkg::SRG_OP_PROG2);
        frm(srg_pkg::OPC_SUSPEND);
        reset_n_i <= 1'b0;
        w(10);
        reset_n_i <= 1'b1;
        w(8);
        st(4'h0);
        `CHK("pin abort", 1'b1, n_abort > 5)
        $display("test reset_abort done");
        close_out();
    end
endmodule // tb_srg_gate
bind srg_gate srg_gate_sva u_srg_gate_sva (.clk_i(clk_i), .srst_i(srst_i),
    .reset_n_i(reset_n_i), .op_suspend_o(op_suspend_o), .op_resume_o(op_resume_o),
    .op_resume_kind_o(op_resume_kind_o), .op_abort_o(op_abort_o),
    .frame_refuse_o(frame_refuse_o), .cmd_exec_o(cmd_exec_o),
    .cmd_opcode_o(cmd_opcode_o), .status_o(status_o));
